// >>> hw/kpm_consts.svh
`ifndef KPM_CONSTS_SVH
`define KPM_CONSTS_SVH
`define KPM_CLK_HZ 200000000
`define KPM_TIMEOUT_MS 10000
`define KPM_TIMEOUT_CYC (`KPM_CLK_HZ / 1000 * `KPM_TIMEOUT_MS)
`define KPM_DEBOUNCE_MS 5
`define KPM_DEBOUNCE_CYC (`KPM_CLK_HZ / 1000 * `KPM_DEBOUNCE_MS)
`define KPM_RESET_HOLD_MS 100
`define KPM_RESET_HOLD_CYC (`KPM_CLK_HZ / 1000 * `KPM_RESET_HOLD_MS)
`define KPM_BLINK_CYC 50000000
`define KPM_ADDR_W 8
`define KPM_VAL_W 16
`define KPM_ATTR_NONE 2'h0
`define KPM_ATTR_OFFLINE 2'h1
`define KPM_ATTR_CUST 2'h2
`define KPM_ATTR_MAKER 2'h3
`define KPM_CLS_PARAM 2'h0
`define KPM_CLS_MAG 2'h1
`define KPM_CLS_DIG 2'h2
`define KPM_MEMCMD_LOAD_DEF 2'h1
`define KPM_MEMCMD_RELOAD 2'h2
`define KPM_MEMCMD_SAVE 2'h3
`endif

// >>> hw/kpm_pkg.sv
package kpm_pkg;
	typedef enum logic [2:0] {
		KPM_IDLE = 3'h0,
		KPM_MENU = 3'h1,
		KPM_VIEW = 3'h3,
		KPM_EDIT = 3'h2,
		KPM_MAG = 3'h6,
		KPM_DIG = 3'h7
	} kpm_mode_e;
	typedef struct packed {
		logic sel;
		logic inc;
		logic dec;
		logic both;
	} kpm_keys_s;
	typedef struct packed {
		logic [1:0] cls;
		logic [1:0] attr;
	} kpm_item_s;
	typedef struct packed {
		logic torque_en;
		logic run_en;
		logic ref1_en;
	} kpm_lin_s;
endpackage

// >>> hw/kpm_filter.sv
`timescale 1ns/1ps
`include "kpm_consts.svh"
module kpm_filter import kpm_pkg::*; #(
	parameter int CNT = `KPM_DEBOUNCE_CYC
) (
	// clock
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic clk_en,
	// pin and result
	input wire logic pin,
	output logic level,
	output logic rise
);
	localparam int CW = $clog2(CNT + 1);
	initial begin
		if (CNT < 1) $error("kpm_filter: CNT must be at least 1");
	end
	logic [2:0] sync_reg;
	logic [CW-1:0] cnt_reg;
	logic level_reg;
	logic rise_reg;
	// stage 0 feeds only stage 1; stages 1 and 2 must agree
	wire agree = sync_reg[1] == sync_reg[2];
	wire differ = agree && (sync_reg[2] != level_reg);
	wire done = differ && (cnt_reg == CW'(CNT - 1));
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			sync_reg <= 3'h0;
			cnt_reg <= '0;
			level_reg <= 1'b0;
			rise_reg <= 1'b0;
		end else if (clk_en) begin
			sync_reg <= {sync_reg[1:0], pin};
			cnt_reg <= (differ && !done) ? cnt_reg + CW'(1) : '0;
			if (done) level_reg <= sync_reg[2];
			rise_reg <= done && sync_reg[2];
		end
	end
	assign level = level_reg;
	assign rise = rise_reg;
endmodule // kpm_filter

// >>> hw/kpm_memseq.sv
`timescale 1ns/1ps
`include "kpm_consts.svh"
module kpm_memseq import kpm_pkg::*; #(
	parameter int AW = `KPM_ADDR_W
) (
	// clock
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic clk_en,
	// request
	input wire logic boot,
	input wire logic [1:0] cmd,
	input wire logic cmd_go,
	// store side
	output logic [1:0] op,
	output logic op_go,
	input wire logic op_done,
	input wire logic op_err,
	// status
	output logic busy,
	output logic mem_err
);
	logic [1:0] op_reg;
	logic go_reg;
	logic busy_reg;
	logic err_reg;
	logic booted_reg;
	wire start_boot = !booted_reg && boot && !busy_reg;
	wire start_cmd = booted_reg && cmd_go && !busy_reg;
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			op_reg <= 2'h0;
			go_reg <= 1'b0;
			busy_reg <= 1'b0;
			err_reg <= 1'b0;
			booted_reg <= 1'b0;
		end else if (clk_en) begin
			go_reg <= start_boot || start_cmd;
			if (start_boot) begin
				op_reg <= `KPM_MEMCMD_RELOAD;
				booted_reg <= 1'b1;
				busy_reg <= 1'b1;
			end else if (start_cmd) begin
				op_reg <= cmd;
				busy_reg <= 1'b1;
			end else if (busy_reg && op_done) begin
				busy_reg <= 1'b0;
				if (op_reg == `KPM_MEMCMD_RELOAD) err_reg <= op_err;
				else if (op_reg == `KPM_MEMCMD_SAVE && !op_err) err_reg <= 1'b0;
			end
		end
	end
	assign op = op_reg;
	assign op_go = go_reg;
	assign busy = busy_reg;
	assign mem_err = err_reg;
endmodule // kpm_memseq

// >>> hw/kpm_ctrl.sv
`timescale 1ns/1ps
`include "kpm_consts.svh"
// Overview of operation
// - three keys, four-and-half digit display
// - idle shows stop, blinks on alarm
// - running idle shows motor speed when display choice is zero
// - ten second inactivity returns menu to idle and view or edit to menu; magnitude and digital display never time out
// - select enters last item, keys scroll
// - attribute letter; reserved implies offline
// - select shows value; returns after timeout
// - both keys enter edit, blink point
// - offline, customer, maker write permissions
// - maker items hidden without maker code
// - select commits; timeout discards edit
// - magnitude shows live value, select returns
// - digital items show H/L, select idles
// - power-on copies stored params to working
// - save command writes working to store
// - unreadable store raises memory alarm; no default load
// - reload command restores stored parameters
// - input one torque, input two run
// - input three enables speed reference
// - alarm reset clears removed causes, 100ms
// - ready when no alarm, running output
// - memory commands default zero, offline
module kpm_ctrl import kpm_pkg::*; #(
	parameter int AW = `KPM_ADDR_W,
	parameter int VW = `KPM_VAL_W,
	parameter int NALM = 14,
	parameter int TIMEOUT_CYC = `KPM_TIMEOUT_CYC,
	parameter int DEBOUNCE_CYC = `KPM_DEBOUNCE_CYC,
	parameter int RESET_HOLD_CYC = `KPM_RESET_HOLD_CYC,
	parameter int BLINK_CYC = `KPM_BLINK_CYC
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic clk_en,
	// keypad pins
	input wire logic key_sel_pin,
	input wire logic key_inc_pin,
	input wire logic key_dec_pin,
	// logic input and output pins
	input wire logic [3:0] lin_pin,
	output logic ready_out,
	output logic running_out,
	output kpm_lin_s lin_func,
	// drive status
	input wire logic drive_running,
	input wire logic [NALM-1:0] alarm_cause,
	output logic [NALM-1:0] alarm_latched,
	input wire logic [AW-1:0] display_choice_setting,
	input wire logic [AW-1:0] motor_speed_display,
	// access codes set
	input wire logic customer_access_code,
	input wire logic maker_access_code,
	// item lookup
	output logic [AW-1:0] item_addr,
	input wire kpm_item_s item_info,
	input wire logic [VW-1:0] item_value,
	// working memory write
	output logic wr_go,
	output logic [AW-1:0] wr_addr,
	output logic [VW-1:0] wr_data,
	// memory commands from working memory connections
	input wire logic load_defaults_cmd,
	input wire logic reload_stored_cmd,
	input wire logic save_stored_cmd,
	output logic [1:0] store_op,
	output logic store_go,
	input wire logic store_done,
	input wire logic store_err,
	output logic store_busy,
	// display
	output kpm_mode_e disp_mode,
	output logic [AW-1:0] disp_addr,
	output logic [VW-1:0] disp_value,
	output logic [1:0] disp_attr,
	output logic disp_stop_text,
	output logic disp_blank,
	output logic disp_dp0
);
	localparam int TW = $clog2(TIMEOUT_CYC + 1);
	localparam int HW = $clog2(RESET_HOLD_CYC + 1);
	localparam int BW = $clog2(BLINK_CYC + 1);
	initial begin
		if (AW < 2 || VW < 2 || NALM < 2 || TIMEOUT_CYC < 2 || RESET_HOLD_CYC < 1 || BLINK_CYC < 2)
			$error("kpm_ctrl: parameter out of range");
	end
	// key front end; three keys only
	logic inc_lv, dec_lv, sel_r, inc_r, dec_r;
	kpm_filter #(.CNT(DEBOUNCE_CYC)) u_sel (.sys_clk(sys_clk), .rstn(rstn), .clk_en(clk_en),
		.pin(key_sel_pin), .level(), .rise(sel_r));
	kpm_filter #(.CNT(DEBOUNCE_CYC)) u_inc (.sys_clk(sys_clk), .rstn(rstn), .clk_en(clk_en),
		.pin(key_inc_pin), .level(inc_lv), .rise(inc_r));
	kpm_filter #(.CNT(DEBOUNCE_CYC)) u_dec (.sys_clk(sys_clk), .rstn(rstn), .clk_en(clk_en),
		.pin(key_dec_pin), .level(dec_lv), .rise(dec_r));
	// logic inputs through the same filter
	logic [3:0] lin_lv;
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_lin
			kpm_filter #(.CNT(DEBOUNCE_CYC)) u_lin (.sys_clk(sys_clk), .rstn(rstn), .clk_en(clk_en),
				.pin(lin_pin[gi]), .level(lin_lv[gi]), .rise());
		end
	endgenerate
	// a press of one key while the other is held counts as the pair, never as a step
	kpm_keys_s keys;
	assign keys.both = (inc_r && dec_lv) || (dec_r && inc_lv);
	assign keys.inc = inc_r && !dec_lv && !keys.both;
	assign keys.dec = dec_r && !inc_lv && !keys.both;
	assign keys.sel = sel_r;
	wire any_key = keys.sel || keys.inc || keys.dec || keys.both;
	kpm_mode_e mode_reg, mode_next;
	logic [AW-1:0] addr_reg, addr_next;
	logic [VW-1:0] edit_reg, edit_next;
	logic touched_reg, touched_next;
	logic [TW-1:0] tmr_reg;
	logic [HW-1:0] hold_reg;
	logic [BW-1:0] blink_cnt_reg;
	logic blink_reg;
	logic [NALM-1:0] alarm_reg;
	logic wr_go_reg, wr_go_next;
	logic [VW-1:0] wr_data_reg;
	logic [AW-1:0] wr_addr_reg;
	logic mem_err;
	logic mem_err_q;
	logic cmd_prev_reg;
	// memory command sequencer; boot copy fires right after reset release
	wire cmd_any = load_defaults_cmd || reload_stored_cmd || save_stored_cmd;
	wire [1:0] cmd_sel = save_stored_cmd ? `KPM_MEMCMD_SAVE :
		reload_stored_cmd ? `KPM_MEMCMD_RELOAD : `KPM_MEMCMD_LOAD_DEF;
	kpm_memseq #(.AW(AW)) u_mem (.sys_clk(sys_clk), .rstn(rstn), .clk_en(clk_en),
		.boot(1'b1), .cmd(cmd_sel), .cmd_go(cmd_any && !cmd_prev_reg),
		.op(store_op), .op_go(store_go), .op_done(store_done), .op_err(store_err),
		.busy(store_busy), .mem_err(mem_err));
	// maker items are skipped while scrolling without maker code
	wire hidden = (item_info.attr == `KPM_ATTR_MAKER) && !maker_access_code;
	wire reserved = (item_info.attr == `KPM_ATTR_CUST) || (item_info.attr == `KPM_ATTR_MAKER);
	wire offline = reserved || (item_info.attr == `KPM_ATTR_OFFLINE);
	wire may_write = (!offline || !drive_running) &&
		(item_info.attr != `KPM_ATTR_CUST || customer_access_code) &&
		(item_info.attr != `KPM_ATTR_MAKER || maker_access_code);
	wire timed_out = tmr_reg == TW'(TIMEOUT_CYC - 1);
	wire no_timeout = (mode_reg == KPM_MAG) || (mode_reg == KPM_DIG);
	logic skip_reg;
	logic skip_up_reg;
	always_comb begin
		mode_next = mode_reg;
		addr_next = addr_reg;
		edit_next = edit_reg;
		touched_next = touched_reg;
		wr_go_next = 1'b0;
		case (mode_reg)
			KPM_IDLE: begin
				if (keys.sel) mode_next = KPM_MENU;
			end
			KPM_MENU: begin
				if (skip_reg && hidden) addr_next = skip_up_reg ? addr_reg + AW'(1) : addr_reg - AW'(1);
				else if (keys.inc) addr_next = addr_reg + AW'(1);
				else if (keys.dec) addr_next = addr_reg - AW'(1);
				else if (keys.sel && !hidden) begin
					case (item_info.cls)
						`KPM_CLS_MAG: mode_next = KPM_MAG;
						`KPM_CLS_DIG: mode_next = KPM_DIG;
						default: mode_next = KPM_VIEW;
					endcase
				end else if (timed_out) mode_next = KPM_IDLE;
			end
			KPM_VIEW: begin
				if (keys.sel || timed_out) mode_next = KPM_MENU;
				else if (keys.both) begin
					mode_next = KPM_EDIT;
					edit_next = item_value;
					touched_next = 1'b0;
				end
			end
			KPM_EDIT: begin
				if (keys.sel) begin
					mode_next = KPM_MENU;
					wr_go_next = touched_reg && may_write;
				end else if (timed_out) mode_next = KPM_MENU;
				else if (keys.inc && may_write) begin
					edit_next = edit_reg + VW'(1);
					touched_next = 1'b1;
				end else if (keys.dec && may_write) begin
					edit_next = edit_reg - VW'(1);
					touched_next = 1'b1;
				end
			end
			KPM_MAG: begin
				if (keys.sel) mode_next = KPM_MENU;
			end
			KPM_DIG: begin
				if (keys.sel) mode_next = KPM_IDLE;
			end
			default: mode_next = KPM_IDLE;
		endcase
	end
	// alarm reset needs the input level held stable for the minimum transition time
	logic rst_done_reg;
	wire rst_held = hold_reg == HW'(RESET_HOLD_CYC);
	wire rst_fire = rst_held && lin_lv[3] && !rst_done_reg;
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			mode_reg <= KPM_IDLE;
			addr_reg <= '0;
			edit_reg <= '0;
			touched_reg <= 1'b0;
			tmr_reg <= '0;
			wr_go_reg <= 1'b0;
			wr_data_reg <= '0;
			wr_addr_reg <= '0;
			skip_reg <= 1'b0;
			skip_up_reg <= 1'b1;
			cmd_prev_reg <= 1'b0;
			mem_err_q <= 1'b0;
		end else if (clk_en) begin
			mode_reg <= mode_next;
			addr_reg <= addr_next;
			edit_reg <= edit_next;
			touched_reg <= touched_next;
			skip_reg <= (mode_reg == KPM_MENU) && (addr_next != addr_reg || skip_reg && hidden);
			// hidden items are passed in the direction of the last step
			if (keys.inc || keys.dec) skip_up_reg <= keys.inc;
			tmr_reg <= (any_key || mode_next != mode_reg || no_timeout || timed_out) ? '0 : tmr_reg + TW'(1);
			wr_go_reg <= wr_go_next;
			if (wr_go_next) begin
				wr_data_reg <= edit_reg;
				wr_addr_reg <= addr_reg;
			end
			cmd_prev_reg <= cmd_any;
			mem_err_q <= mem_err;
		end
	end
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			hold_reg <= '0;
			rst_done_reg <= 1'b0;
			alarm_reg <= '0;
		end else if (clk_en) begin
			if (!lin_lv[3]) hold_reg <= '0;
			else if (!rst_held) hold_reg <= hold_reg + HW'(1);
			rst_done_reg <= lin_lv[3] && (rst_done_reg || rst_held);
			// a live cause sets over a clear in the same cycle
			alarm_reg <= (rst_fire ? '0 : alarm_reg) | alarm_cause |
				{{(NALM-2){1'b0}}, mem_err_q, 1'b0};
		end
	end
	// blink timebase for alarm stop text and edit point
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			blink_cnt_reg <= '0;
			blink_reg <= 1'b0;
		end else if (clk_en) begin
			blink_cnt_reg <= (blink_cnt_reg == BW'(BLINK_CYC - 1)) ? '0 : blink_cnt_reg + BW'(1);
			if (blink_cnt_reg == BW'(BLINK_CYC - 1)) blink_reg <= !blink_reg;
		end
	end
	wire alarm_any = |alarm_reg;
	wire idle = mode_reg == KPM_IDLE;
	wire use_speed = drive_running && (display_choice_setting == '0);
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			disp_mode <= KPM_IDLE;
			disp_addr <= '0;
			disp_value <= '0;
			disp_attr <= `KPM_ATTR_NONE;
			disp_stop_text <= 1'b1;
			disp_blank <= 1'b0;
			disp_dp0 <= 1'b0;
			ready_out <= 1'b0;
			running_out <= 1'b0;
			lin_func <= '0;
		end else if (clk_en) begin
			disp_mode <= mode_reg;
			disp_addr <= idle ? (use_speed ? motor_speed_display : display_choice_setting) : addr_reg;
			disp_value <= (mode_reg == KPM_EDIT) ? edit_reg : item_value;
			disp_attr <= item_info.attr;
			disp_stop_text <= idle && !drive_running;
			disp_blank <= idle && !drive_running && alarm_any && blink_reg;
			disp_dp0 <= (mode_reg == KPM_EDIT) && blink_reg;
			ready_out <= !alarm_any;
			running_out <= drive_running;
			lin_func.torque_en <= lin_lv[0];
			lin_func.run_en <= lin_lv[1] && !alarm_any;
			lin_func.ref1_en <= lin_lv[2];
		end
	end
	assign alarm_latched = alarm_reg;
	assign item_addr = addr_reg;
	assign wr_go = wr_go_reg;
	assign wr_addr = wr_addr_reg;
	assign wr_data = wr_data_reg;
endmodule // kpm_ctrl

// >>> sim/kpm_ctrl_checker.sv
`timescale 1ns/1ps
`include "kpm_consts.svh"
module kpm_ctrl_checker import kpm_pkg::*; #(
	parameter int NALM = 14
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rstn,
	// status
	input wire logic drive_running,
	input wire logic [NALM-1:0] alarm_latched,
	input wire logic ready_out,
	input wire logic running_out,
	input wire logic customer_access_code,
	input wire logic maker_access_code,
	// item and store
	input wire kpm_item_s item_info,
	input wire logic wr_go,
	input wire logic store_go,
	input wire logic [1:0] store_op,
	input wire logic store_busy,
	// display
	input wire kpm_mode_e disp_mode,
	input wire logic disp_stop_text,
	input wire logic disp_dp0
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	sequence s_pulse;
		store_go ##1 !store_go;
	endsequence
	sequence s_boot;
		##[0:3] (store_go && store_op == `KPM_MEMCMD_RELOAD);
	endsequence
	wire [1:0] at = item_info.attr;
	wire maker_vis = disp_mode == KPM_MENU && !maker_access_code && at == `KPM_ATTR_MAKER;
	// every reserved item is offline as well
	wire off_ok = !(drive_running && at != `KPM_ATTR_NONE);
	wire wr_ok = off_ok && (at != `KPM_ATTR_CUST || customer_access_code) && (at != `KPM_ATTR_MAKER || maker_access_code);
	wire idle_stop = disp_mode == KPM_IDLE && !drive_running && alarm_latched == '0;
	a_ready_alarm: assert property ((alarm_latched != '0) [*2] |-> !ready_out)
		else $error("ready high with alarm");
	a_running_follow: assert property (drive_running [*3] |-> running_out)
		else $error("running output missing");
	a_store_pulse: assert property (store_go |-> s_pulse)
		else $error("store go not a pulse");
	a_store_busy: assert property (store_go |-> ##[0:1] store_busy)
		else $error("store busy missing");
	a_boot_reload: assert property ($rose(rstn) |-> s_boot)
		else $error("no boot reload");
	a_write_perm: assert property (wr_go |-> wr_ok)
		else $error("write not permitted");
	a_write_edit: assert property (wr_go |-> $past(disp_mode) == KPM_EDIT || $past(disp_mode, 2) == KPM_EDIT)
		else $error("write outside edit");
	a_maker_hidden: assert property (not (maker_vis [*4]))
		else $error("maker item listed");
	a_dp_edit: assert property ((disp_mode != KPM_EDIT) [*3] |-> !disp_dp0)
		else $error("edit point outside edit");
	a_idle_stop: assert property (idle_stop [*3] |-> disp_stop_text)
		else $error("stop text missing");
	a_idle_speed: assert property ((disp_mode == KPM_IDLE && drive_running) [*4] |-> !disp_stop_text)
		else $error("stop text while running");
endmodule // kpm_ctrl_checker
bind kpm_ctrl kpm_ctrl_checker #(.NALM(NALM)) u_chk (
	.sys_clk(sys_clk),
	.rstn(rstn),
	.drive_running(drive_running),
	.alarm_latched(alarm_latched),
	.ready_out(ready_out),
	.running_out(running_out),
	.customer_access_code(customer_access_code),
	.maker_access_code(maker_access_code),
	.item_info(item_info),
	.wr_go(wr_go),
	.store_go(store_go),
	.store_op(store_op),
	.store_busy(store_busy),
	.disp_mode(disp_mode),
	.disp_stop_text(disp_stop_text),
	.disp_dp0(disp_dp0)
);

// >>> sim/kpm_store_model.sv
`timescale 1ns/1ps
`include "kpm_consts.svh"
module kpm_store_model import kpm_pkg::*; (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rstn,
	// item lookup
	input wire logic [7:0] item_addr,
	output kpm_item_s item_info,
	output logic [15:0] item_value,
	// working memory write
	input wire logic wr_go,
	input wire logic [7:0] wr_addr,
	input wire logic [15:0] wr_data,
	// store
	input wire logic [1:0] store_op,
	input wire logic store_go,
	output logic store_done,
	output logic store_err,
	// fault injection: a reload reports unreadable contents
	input wire logic bad
);
	logic [15:0] ram [8];
	logic [15:0] eep [8];
	logic [2:0] dly;
	logic [1:0] op;
	wire [2:0] ia = item_addr[2:0];
	// table repeats every eight addresses, so one maker item per block
	assign item_info.cls = ia == 3'h4 ? `KPM_CLS_MAG : ia == 3'h5 ? `KPM_CLS_DIG : `KPM_CLS_PARAM;
	assign item_info.attr = ia == 3'h1 ? `KPM_ATTR_OFFLINE : ia == 3'h2 ? `KPM_ATTR_CUST :
		ia == 3'h3 ? `KPM_ATTR_MAKER : `KPM_ATTR_NONE;
	assign item_value = ram[ia];
	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			dly <= 3'h0;
			op <= 2'h0;
			store_done <= 1'b0;
			store_err <= 1'b0;
			for (int i = 0; i < 8; i++) begin
				eep[i] <= 16'h0010 + 16'(i);
				ram[i] <= 16'h0BAD;
			end
		end else begin
			store_done <= dly == 3'h1;
			store_err <= dly == 3'h1 && op == `KPM_MEMCMD_RELOAD && bad;
			if (store_go) begin
				dly <= 3'h4;
				op <= store_op;
			end else if (dly != 3'h0) begin
				dly <= dly - 3'h1;
			end
			for (int i = 0; i < 8; i++) begin
				if (dly == 3'h1 && op == `KPM_MEMCMD_SAVE) eep[i] <= ram[i];
				if (dly == 3'h1 && op == `KPM_MEMCMD_RELOAD) ram[i] <= eep[i];
				if (dly == 3'h1 && op == `KPM_MEMCMD_LOAD_DEF) ram[i] <= 16'h0000;
			end
			if (wr_go) ram[wr_addr[2:0]] <= wr_data;
		end
	end
endmodule // kpm_store_model

// >>> sim/kpm_ctrl_tb.sv
`timescale 1ns/1ps
`define CHK(n, e, a) begin check_count++; if ((a) !== (e)) begin fails++; \
	$display("wrong value %s exp %0h got %0h", n, e, a); end end
module kpm_ctrl_tb import kpm_pkg::*;;
	localparam int TO = 200;
	logic sys_clk = 1'b0;
	logic rstn = 1'b0;
	logic ks = 1'b0, ki = 1'b0, kd = 1'b0, run = 1'b0, cust = 1'b0;
	logic ld = 1'b0, rl = 1'b0, sv = 1'b0, bad = 1'b0, ce = 1'b1, mk = 1'b0;
	logic [7:0] dch = 8'h00;
	logic [3:0] lin = 4'h0;
	logic [13:0] cause = 14'h0;
	logic rdy, runo, wr_go, st_go, st_done, st_err, st_busy, stop, blank, dp0;
	kpm_lin_s lf;
	kpm_item_s info;
	kpm_mode_e mode;
	logic [13:0] latched;
	logic [7:0] ia, wa, daddr;
	logic [15:0] ival, wd, dval;
	logic [1:0] sop, dattr;
	int fails = 0, check_count = 0, wr_cnt = 0, cyc = 0;
	initial forever #2.5 sys_clk = ~sys_clk;
	kpm_ctrl #(.TIMEOUT_CYC(TO), .DEBOUNCE_CYC(4), .RESET_HOLD_CYC(20), .BLINK_CYC(8)) u_dut (
		.sys_clk(sys_clk), .rstn(rstn), .clk_en(ce),
		.key_sel_pin(ks), .key_inc_pin(ki), .key_dec_pin(kd),
		.lin_pin(lin), .ready_out(rdy), .running_out(runo), .lin_func(lf),
		.drive_running(run), .alarm_cause(cause), .alarm_latched(latched),
		.display_choice_setting(dch), .motor_speed_display(8'h05),
		.customer_access_code(cust), .maker_access_code(mk),
		.item_addr(ia), .item_info(info), .item_value(ival),
		.wr_go(wr_go), .wr_addr(wa), .wr_data(wd),
		.load_defaults_cmd(ld), .reload_stored_cmd(rl), .save_stored_cmd(sv),
		.store_op(sop), .store_go(st_go), .store_done(st_done), .store_err(st_err), .store_busy(st_busy),
		.disp_mode(mode), .disp_addr(daddr), .disp_value(dval), .disp_attr(dattr),
		.disp_stop_text(stop), .disp_blank(blank), .disp_dp0(dp0));
	kpm_store_model u_store (
		.sys_clk(sys_clk), .rstn(rstn), .item_addr(ia), .item_info(info), .item_value(ival),
		.wr_go(wr_go), .wr_addr(wa), .wr_data(wd),
		.store_op(sop), .store_go(st_go), .store_done(st_done), .store_err(st_err), .bad(bad));
	always @(posedge sys_clk) begin
		cyc++;
		if (wr_go === 1'b1) wr_cnt++;
		if (cyc == 20000) begin
			fails++;
			finish_test();
		end
	end
	task automatic wt(input int n);
		repeat (n) @(negedge sys_clk);
	endtask
	// keys are held well past sync and debounce so each press is taken once
	task automatic press(input logic [2:0] k);
		{ks, ki, kd} = k;
		wt(12);
		{ks, ki, kd} = 3'h0;
		wt(12);
	endtask
	task automatic edit_once();
		press(3'b011);
		press(3'b010);
		press(3'b100);
	endtask
	task automatic wait_go();
		int i = 0;
		while (st_go !== 1'b1 && i < 50) begin
			@(negedge sys_clk);
			i++;
		end
		`CHK("store go", 1'b1, st_go)
	endtask
	task automatic t_boot();
		`CHK("mode", KPM_IDLE, mode)
		`CHK("stop", 1'b1, stop)
		wait_go();
		`CHK("boot op", 2'h2, sop)
		wt(10);
		`CHK("ready", 1'b1, rdy)
		// a frozen clock enable must swallow a whole key press
		ce = 1'b0;
		press(3'b100);
		`CHK("frozen mode", KPM_IDLE, mode)
		ce = 1'b1;
	endtask
	task automatic t_edit();
		logic seen = 1'b0;
		press(3'b100);
		`CHK("mode", KPM_MENU, mode)
		`CHK("addr", 8'h00, daddr)
		press(3'b100);
		`CHK("mode", KPM_VIEW, mode)
		`CHK("value", 16'h0010, dval)
		press(3'b011);
		`CHK("mode", KPM_EDIT, mode)
		`CHK("value", 16'h0010, dval)
		repeat (20) begin
			@(negedge sys_clk);
			seen = seen | (dp0 === 1'b1);
		end
		`CHK("edit point", 1'b1, seen)
		press(3'b010);
		press(3'b100);
		`CHK("mode", KPM_MENU, mode)
		`CHK("wr data", 16'h0011, wd)
		`CHK("wr addr", 8'h00, wa)
		`CHK("writes", 1, wr_cnt)
		press(3'b100);
		wt(TO + 40);
		`CHK("mode", KPM_MENU, mode)
		press(3'b100);
		press(3'b011);
		press(3'b010);
		wt(TO + 40);
		`CHK("mode", KPM_MENU, mode)
		`CHK("writes", 1, wr_cnt)
		wt(TO + 40);
		`CHK("mode", KPM_IDLE, mode)
	endtask
	task automatic t_scroll();
		press(3'b100);
		press(3'b010);
		press(3'b010);
		`CHK("addr", 8'h02, daddr)
		`CHK("attr", 2'h2, dattr)
		press(3'b010);
		`CHK("addr", 8'h04, daddr)
		press(3'b100);
		`CHK("mode", KPM_MAG, mode)
		`CHK("mag value", 16'h0014, dval)
		wt(TO + 40);
		`CHK("mode", KPM_MAG, mode)
		press(3'b100);
		`CHK("mode", KPM_MENU, mode)
		press(3'b010);
		press(3'b100);
		`CHK("mode", KPM_DIG, mode)
		`CHK("dig value", 16'h0015, dval)
		press(3'b100);
		`CHK("mode", KPM_IDLE, mode)
	endtask
	task automatic t_perm();
		run = 1'b1;
		wt(10);
		`CHK("stop", 1'b0, stop)
		`CHK("speed addr", 8'h05, daddr)
		`CHK("running", 1'b1, runo)
		dch = 8'h07;
		wt(3);
		`CHK("choice addr", 8'h07, daddr)
		dch = 8'h00;
		press(3'b100);
		press(3'b001);
		press(3'b001);
		press(3'b001);
		`CHK("addr", 8'h01, daddr)
		press(3'b100);
		edit_once();
		`CHK("writes", 1, wr_cnt)
		run = 1'b0;
		press(3'b010);
		press(3'b100);
		edit_once();
		`CHK("writes", 1, wr_cnt)
		cust = 1'b1;
		press(3'b100);
		edit_once();
		`CHK("writes", 2, wr_cnt)
		// with the maker code the maker item is listed and writable
		mk = 1'b1;
		press(3'b010);
		`CHK("addr", 8'h03, daddr)
		press(3'b100);
		edit_once();
		`CHK("writes", 3, wr_cnt)
		`CHK("wr addr", 8'h03, wa)
		wt(TO + 40);
	endtask
	task automatic t_mem();
		for (int k = 0; k < 3; k++) begin
			bad = (k == 1);
			{ld, rl, sv} = 3'b001 << k;
			wait_go();
			`CHK("op", 2'(3 - k), sop)
			wt(1);
			`CHK("busy", 1'b1, st_busy)
			wt(10);
			{ld, rl, sv} = 3'h0;
			wt(3);
		end
		// the failed reload leaves the memory alarm; defaults are saved over it
		`CHK("mem alarm", 1'b1, latched[1])
		`CHK("ready", 1'b0, rdy)
		sv = 1'b1;
		wait_go();
		`CHK("op", 2'h3, sop)
		wt(10);
		sv = 1'b0;
		wt(3);
	endtask
	task automatic t_alarm();
		logic seen = 1'b0;
		cause = 14'h0001;
		wt(5);
		`CHK("latched", 1'b1, latched[0])
		`CHK("ready", 1'b0, rdy)
		repeat (40) begin
			@(negedge sys_clk);
			seen = seen | (blank === 1'b1);
		end
		`CHK("blink", 1'b1, seen)
		lin = 4'b1010; // reset level held far past the minimum
		wt(40);
		`CHK("latched", 1'b1, latched[0])
		`CHK("run en", 1'b0, lf.run_en)
		cause = 14'h0;
		lin = 4'b0010;
		wt(30);
		lin = 4'b1010;
		wt(40);
		`CHK("latched", 14'h0, latched)
		`CHK("ready", 1'b1, rdy)
		lin = 4'b0101;
		wt(30);
		`CHK("lin func", 3'b101, lf)
	endtask
	task automatic finish_test();
		if (fails == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		wt(10);
		rstn = 1'b1;
		t_boot();
		t_edit();
		t_scroll();
		t_perm();
		t_mem();
		t_alarm();
		finish_test();
	end
endmodule // kpm_ctrl_tb
